// [rtl/config_word_decode.sv]
// Configuration word storage, write policing and decode
// Operation
// - Clock-source field picks watchdog reference
// - Window field sets power-on window, 110 as 111
// - Mode 00 off; mode 01 follows software
// - Mode 10 stops in sleep; 11 always
// - Period codes fixed; 10011-11110 fall back 1:32
// - Low-voltage bit forces master-clear pin function
// - Low-voltage bit not clearable during LV programming
// - Write-protect bits: zero protects region
// - Boot/storage protection only when region enabled
// - Storage-area enable bit active low
// - Boot-block enable bit active low
// - Boot size writable only while boot disabled
// - Protection bits sticky until bulk erase
// - Boot size codes 111..010 give 512..16384
// - Boot size clamped to half program memory
// - Unimplemented and blank bits read one
// - Code-protect bit active low
// - Code protect blocks external access, reads zero
`timescale 1ns/1ps
`default_nettype none
module config_word_decode
    import config_word_pkg::*;
(
    input wire logic i_mclk,
    input wire logic i_rst,
    input wire logic i_cfg_reload,      // Device reset request, relatch words
    input wire logic [3:0] i_addr,
    input wire logic [13:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    input wire logic i_lv_prog_active,  // Programming through LV interface
    input wire logic i_master_clear_pin_enable, // From supervisor word
    input wire logic i_wdog_software_enable,
    input wire logic i_sleep,
    input wire logic i_ext_pm_wr,       // External program memory write
    input wire logic [13:0] i_ext_pm_rdata,
    output logic [13:0] o_rdata,
    output wdog_cfg_t o_wdog,
    output mem_prot_t o_prot,
    output logic o_ext_pm_wr_en,
    output logic [13:0] o_ext_pm_rdata
);

    // Stored (non-volatile image) words
    logic [13:0] nv_wdog_r, nv_wdog_nxt;
    logic [13:0] nv_mem_r, nv_mem_nxt;
    logic [13:0] nv_cp_r, nv_cp_nxt;
    // Copies latched at reset; decode only ever sees these
    logic [13:0] act_wdog_r, act_wdog_nxt;
    logic [13:0] act_mem_r, act_mem_nxt;
    logic [13:0] act_cp_r, act_cp_nxt;
    // Output registers
    logic [13:0] rdata_r, rdata_nxt;
    wdog_cfg_t wdog_r, wdog_nxt;
    mem_prot_t prot_r, prot_nxt;
    logic ext_wr_r, ext_wr_nxt;
    logic [13:0] ext_rdata_r, ext_rdata_nxt;

    // Period code to power-on period setting
    function automatic logic [4:0] period_map(input logic [4:0] code);
        if (code == PERIOD_DEFAULT) begin
            period_map = PERIOD_DEFAULT_LOAD;
        end else if (code > PERIOD_MAX_FIXED) begin
            period_map = PERIOD_FALLBACK;
        end else begin
            period_map = code;
        end
    endfunction : period_map

    // Boot size exponent, clamped to half of program memory
    function automatic logic [4:0] boot_log2(input logic [2:0] code);
        logic [4:0] lg;
        lg = BOOT_LOG2_MIN + (5'h07 - {2'b00, code});
        if (lg > PROG_MEM_LOG2 - 5'h01) begin
            lg = PROG_MEM_LOG2 - 5'h01;
        end
        boot_log2 = lg;
    endfunction : boot_log2

    // Store policing: unimplemented ones, sticky bits, LV lock, size lock
    always_comb begin
        nv_wdog_nxt = nv_wdog_r;
        nv_mem_nxt = nv_mem_r;
        nv_cp_nxt = nv_cp_r;
        if (i_wr && i_addr == ERASE_ADDR) begin
            // Bulk erase is the only way back to unprotected
            nv_wdog_nxt = BLANK_WORD;
            nv_mem_nxt = BLANK_WORD;
            nv_cp_nxt = BLANK_WORD;
        end else if (i_wr && i_addr == WDOG_WORD_ADDR) begin
            nv_wdog_nxt = i_wdata | WDOG_UNIMP;
        end else if (i_wr && i_addr == MEM_WORD_ADDR) begin
            // Plain bits take the data, sticky bits can only drop
            nv_mem_nxt = (i_wdata & ~MEM_STICKY)
                | (i_wdata & nv_mem_r & MEM_STICKY) | MEM_UNIMP;
            // Refuse dropping out of LV mode from inside it
            if (i_lv_prog_active) begin
                nv_mem_nxt[LVP_BIT] = nv_mem_r[LVP_BIT];
            end
            // Size field frozen once the boot block is enabled
            if (!nv_mem_r[BOOT_EN_N_BIT]) begin
                nv_mem_nxt[BOOT_SIZE_LSB +: 3] =
                    nv_mem_r[BOOT_SIZE_LSB +: 3];
            end
        end else if (i_wr && i_addr == CP_WORD_ADDR) begin
            nv_cp_nxt = (i_wdata & nv_cp_r & CP_STICKY)
                | CP_UNIMP;
        end
    end

    // Stored words come up blank at power-on reset
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            nv_wdog_r <= BLANK_WORD;
            nv_mem_r <= BLANK_WORD;
            nv_cp_r <= BLANK_WORD;
        end else begin
            nv_wdog_r <= nv_wdog_nxt;
            nv_mem_r <= nv_mem_nxt;
            nv_cp_r <= nv_cp_nxt;
        end
    end

    // Latch the words only during reset, so programming mid-run
    // does not disturb a running watchdog or protection map
    always_comb begin
        act_wdog_nxt = act_wdog_r;
        act_mem_nxt = act_mem_r;
        act_cp_nxt = act_cp_r;
        if (i_rst || i_cfg_reload) begin
            act_wdog_nxt = nv_wdog_r;
            act_mem_nxt = nv_mem_r;
            act_cp_nxt = nv_cp_r;
        end
    end

    // Latched copy registers; reset loads from store, not a constant
    always_ff @(posedge i_mclk) begin
        act_wdog_r <= act_wdog_nxt;
        act_mem_r <= act_mem_nxt;
        act_cp_r <= act_cp_nxt;
    end

    // Decode of the latched words and external access gating
    always_comb begin
        logic [2:0] clk_code;
        logic [2:0] win_code;
        logic [1:0] mode;
        logic [4:0] period_code;
        logic boot_en;
        logic saf_en;
        logic [16:0] size;
        clk_code = act_wdog_r[CLK_SRC_LSB +: 3];
        win_code = act_wdog_r[WINDOW_LSB +: 3];
        mode = act_wdog_r[MODE_LSB +: 2];
        period_code = act_wdog_r[PERIOD_LSB +: 5];
        boot_en = !act_mem_r[BOOT_EN_N_BIT];
        saf_en = SAF_PRESENT && !act_mem_r[SAF_EN_N_BIT];
        size = 17'h00000;
        wdog_nxt = wdog_r;
        prot_nxt = prot_r;

        // Clock source, reserved codes flagged as such
        case (clk_code)
            3'h0: wdog_nxt.clk_src = CLK_MED_FREQ_INTOSC;
            3'h1: wdog_nxt.clk_src = CLK_LOW_FREQ_INTOSC;
            3'h7: wdog_nxt.clk_src = CLK_SOFTWARE;
            default: wdog_nxt.clk_src = CLK_RESERVED;
        endcase

        // Window: 110 behaves exactly as the open software code
        if (win_code == WINDOW_ALIAS || win_code == WINDOW_SOFT) begin
            wdog_nxt.window = WINDOW_SOFT;
            wdog_nxt.window_locked = 1'b0;
        end else begin
            wdog_nxt.window = win_code;
            wdog_nxt.window_locked = 1'b1;
        end

        // Operating mode; software enable matters only in mode 01
        case (mode)
            2'h0: wdog_nxt.running = 1'b0;
            2'h1: wdog_nxt.running = i_wdog_software_enable;
            2'h2: wdog_nxt.running = !i_sleep;
            default: wdog_nxt.running = 1'b1;
        endcase

        wdog_nxt.period = period_map(period_code);
        wdog_nxt.period_locked = (period_code != PERIOD_DEFAULT);

        // Pin function and programming entry
        prot_nxt.mclr_is_reset = act_mem_r[LVP_BIT]
            || i_master_clear_pin_enable;
        prot_nxt.hv_prog_required = !act_mem_r[LVP_BIT];

        // Region protection, zero protects
        prot_nxt.saf_enabled = saf_en;
        prot_nxt.saf_protected = saf_en
            && !act_mem_r[WR_SAF_BIT];
        prot_nxt.eeprom_protected = !act_mem_r[WR_EEPROM_BIT];
        prot_nxt.config_protected = !act_mem_r[WR_CONFIG_BIT];
        prot_nxt.app_protected = !act_mem_r[WR_APP_BIT];
        prot_nxt.boot_enabled = boot_en;
        prot_nxt.boot_protected = boot_en
            && !act_mem_r[WR_BOOT_BIT];

        // Boot size is zero words while disabled
        if (boot_en) begin
            size = 17'h00001 << boot_log2(act_mem_r[BOOT_SIZE_LSB +: 3]);
        end
        prot_nxt.boot_size = size;
        prot_nxt.boot_last = boot_en ? 16'(size - 17'h00001) : 16'h0000;

        // External access inhibited under code protection
        ext_wr_nxt = i_ext_pm_wr && act_cp_r[CP_N_BIT];
        ext_rdata_nxt = act_cp_r[CP_N_BIT] ? i_ext_pm_rdata
            : 14'h0000;
    end

    // Register read path; data stands in the cycle after the strobe
    always_comb begin
        rdata_nxt = rdata_r;
        if (i_rd) begin
            case (i_addr)
                WDOG_WORD_ADDR: rdata_nxt = nv_wdog_r;
                MEM_WORD_ADDR: rdata_nxt = nv_mem_r;
                CP_WORD_ADDR: rdata_nxt = nv_cp_r;
                default: rdata_nxt = UNMAPPED_RDATA;
            endcase
        end
    end

    // Output flops; decoded outputs held at all zeros during reset
    always_ff @(posedge i_mclk) begin
        if (i_rst) begin
            rdata_r <= 14'h0000;
            wdog_r <= '0;
            prot_r <= '0;
            ext_wr_r <= 1'b0;
            ext_rdata_r <= 14'h0000;
        end else begin
            rdata_r <= rdata_nxt;
            wdog_r <= wdog_nxt;
            prot_r <= prot_nxt;
            ext_wr_r <= ext_wr_nxt;
            ext_rdata_r <= ext_rdata_nxt;
        end
    end

    assign o_rdata = rdata_r;
    assign o_wdog = wdog_r;
    assign o_prot = prot_r;
    assign o_ext_pm_wr_en = ext_wr_r;
    assign o_ext_pm_rdata = ext_rdata_r;

    // Checks on the policing and decode
    default clocking cb @(posedge i_mclk); endclocking
    default disable iff (i_rst);

    a_lvp_clear_refused: assert property (
        i_wr && i_addr == MEM_WORD_ADDR && i_lv_prog_active
        && nv_mem_r[LVP_BIT] |=> nv_mem_r[LVP_BIT])
        else $error("LV bit cleared during LV programming");

    a_sticky_no_release: assert property (
        !(i_wr && i_addr == ERASE_ADDR) |=>
        ((nv_mem_r & ~$past(nv_mem_r) & MEM_STICKY) == 14'h0000))
        else $error("Sticky protection released without erase");

    a_unimp_reads_one: assert property (
        i_rd |=> (((nv_mem_r & MEM_UNIMP) == MEM_UNIMP)
        && ((nv_cp_r & CP_UNIMP) == CP_UNIMP)))
        else $error("Unimplemented bit stored as zero");

    a_size_lock: assert property (
        i_wr && i_addr == MEM_WORD_ADDR && !nv_mem_r[BOOT_EN_N_BIT]
        |=> nv_mem_r[2:0] == $past(nv_mem_r[2:0]))
        else $error("Boot size changed while boot block enabled");

    a_mode_off: assert property (
        act_wdog_r[MODE_LSB +: 2] == 2'h0 ##1
        act_wdog_r[MODE_LSB +: 2] == 2'h0 |-> !o_wdog.running)
        else $error("Watchdog running in disabled mode");

    a_mode_sleep: assert property (
        act_wdog_r[MODE_LSB +: 2] == 2'h2 && i_sleep && !i_cfg_reload
        |=> !o_wdog.running)
        else $error("Watchdog running in sleep under mode 10");

    a_period_default: assert property (
        act_wdog_r[4:0] == PERIOD_DEFAULT && !i_cfg_reload
        |=> o_wdog.period == PERIOD_DEFAULT_LOAD && !o_wdog.period_locked)
        else $error("Default period code decoded wrongly");

    a_cp_read_zero: assert property (
        !act_cp_r[CP_N_BIT] && !i_cfg_reload
        |=> o_ext_pm_rdata == 14'h0000 && !o_ext_pm_wr_en)
        else $error("External access passed under code protection");

    a_boot_clamp: assert property (
        o_prot.boot_size <= (17'h00001 << (PROG_MEM_LOG2 - 5'h01)))
        else $error("Boot size above half of program memory");

    a_latch_reload: assert property (
        i_cfg_reload |=> act_mem_r == $past(nv_mem_r)
        && act_wdog_r == $past(nv_wdog_r))
        else $error("Words not latched on reload");

    c_bulk_erase: cover property (i_wr && i_addr == ERASE_ADDR
        && nv_mem_r != BLANK_WORD);
    c_lvp_refused: cover property (i_wr && i_addr == MEM_WORD_ADDR
        && i_lv_prog_active && !i_wdata[LVP_BIT]);
    c_cp_blocked: cover property (!act_cp_r[CP_N_BIT] && i_ext_pm_wr);
    c_boot_clamped: cover property (prot_r.boot_enabled
        && act_mem_r[2:0] == 3'h0);

endmodule : config_word_decode
`default_nettype wire

// [rtl/config_word_pkg.sv]
// Package: offsets, field positions, blank values and decoded-config carriers
package config_word_pkg;

    // Register port map (word index on the plain register port)
    localparam logic [3:0] WDOG_WORD_ADDR = 4'h0;  // Watchdog config word
    localparam logic [3:0] MEM_WORD_ADDR = 4'h1;   // Memory config word
    localparam logic [3:0] CP_WORD_ADDR = 4'h2;    // Code-protect config word
    localparam logic [3:0] ERASE_ADDR = 4'h3;      // Write: bulk erase
    localparam logic [13:0] UNMAPPED_RDATA = 14'h0000;

    // Blank / bulk-erased value of every word
    localparam logic [13:0] BLANK_WORD = 14'h3fff;

    // Unimplemented bits, forced to one on every store
    localparam logic [13:0] WDOG_UNIMP = 14'h0080;
    localparam logic [13:0] MEM_UNIMP = 14'h1060;
    localparam logic [13:0] CP_UNIMP = 14'h3ffe;
    // Sticky bits: may only go from one to zero outside a bulk erase
    localparam logic [13:0] MEM_STICKY = 14'h0f98;
    localparam logic [13:0] CP_STICKY = 14'h0001;

    // Watchdog word field positions
    localparam int CLK_SRC_LSB = 11;
    localparam int WINDOW_LSB = 8;
    localparam int MODE_LSB = 5;
    localparam int PERIOD_LSB = 0;
    // Memory word bit positions
    localparam int LVP_BIT = 13;
    localparam int WR_SAF_BIT = 11;
    localparam int WR_EEPROM_BIT = 10;
    localparam int WR_CONFIG_BIT = 9;
    localparam int WR_BOOT_BIT = 8;
    localparam int WR_APP_BIT = 7;
    localparam int SAF_EN_N_BIT = 4;
    localparam int BOOT_EN_N_BIT = 3;
    localparam int BOOT_SIZE_LSB = 0;
    localparam int CP_N_BIT = 0;

    // Decode constants
    localparam logic [2:0] WINDOW_SOFT = 3'h7;     // Fully open, software owned
    localparam logic [2:0] WINDOW_ALIAS = 3'h6;    // Acts as the soft code
    localparam logic [4:0] PERIOD_MAX_FIXED = 5'h12;
    localparam logic [4:0] PERIOD_FALLBACK = 5'h00;
    localparam logic [4:0] PERIOD_DEFAULT = 5'h1f;
    localparam logic [4:0] PERIOD_DEFAULT_LOAD = 5'h0b;
    localparam logic [4:0] BOOT_LOG2_MIN = 5'h09;  // 512 words for code 111
    localparam logic [4:0] PROG_MEM_LOG2 = 5'h0f;  // User program memory size
    localparam bit SAF_PRESENT = 1'b1;             // Storage area implemented

    // Watchdog clock choice
    typedef enum logic [1:0] {
        CLK_MED_FREQ_INTOSC,
        CLK_LOW_FREQ_INTOSC,
        CLK_SOFTWARE,
        CLK_RESERVED
    } wdog_clk_src_t;

    // Decoded watchdog setup
    typedef struct packed {
        wdog_clk_src_t clk_src;
        logic [2:0] window;       // Power-on window setting
        logic window_locked;      // Fixed, keyed access needed
        logic running;            // Watchdog counting now
        logic [4:0] period;       // Power-on period setting
        logic period_locked;      // Software cannot change period
    } wdog_cfg_t;

    // Decoded memory options
    typedef struct packed {
        logic mclr_is_reset;
        logic hv_prog_required;
        logic saf_enabled;
        logic saf_protected;
        logic eeprom_protected;
        logic config_protected;
        logic app_protected;
        logic boot_enabled;
        logic boot_protected;
        logic [16:0] boot_size;   // Words, zero when disabled
        logic [15:0] boot_last;   // Last boot word address
    } mem_prot_t;

endpackage : config_word_pkg

// [test/cfg_programmer_model.sv]
// Behavioural model of the external programmer on the register port
`timescale 1ns/1ps
`default_nettype none
module cfg_programmer_model (
    input wire logic i_mclk,
    input wire logic [13:0] i_rdata,
    output logic [3:0] o_addr,
    output logic [13:0] o_wdata,
    output logic o_wr,
    output logic o_rd,
    output logic o_lv_prog_active
);
    // Idle port at time zero, no programming session open
    initial begin
        o_addr = 4'h0;
        o_wdata = 14'h0000;
        o_wr = 1'b0;
        o_rd = 1'b0;
        o_lv_prog_active = 1'b0;
    end

    // Open or close a session over the low-voltage interface
    task automatic set_lv(input logic v);
        @(posedge i_mclk);
        o_lv_prog_active <= v;
    endtask : set_lv

    // One-cycle write; data goes to its inverse once released
    task automatic put_word(input logic [3:0] a, input logic [13:0] d);
        @(posedge i_mclk);
        o_addr <= a;
        o_wdata <= d;
        o_wr <= 1'b1;
        @(posedge i_mclk);
        o_wr <= 1'b0;
        o_wdata <= ~d;
    endtask : put_word

    // One-cycle read; data stands from the following cycle until the next read
    task automatic get_word(input logic [3:0] a, output logic [13:0] d);
        @(posedge i_mclk);
        o_addr <= a;
        o_rd <= 1'b1;
        @(posedge i_mclk);
        o_rd <= 1'b0;
        #1;
        d = i_rdata;
    endtask : get_word
endmodule : cfg_programmer_model
`default_nettype wire

// [test/config_word_decode_bench.sv]
// Self-checking bench for the configuration word decoder
`timescale 1ns/1ps
`default_nettype none
module config_word_decode_bench import config_word_pkg::*;;
    logic mclk, rst, reload, mce, swen, sleep, ext_wr, ext_wr_o;
    logic [13:0] ext_rd, ext_rd_o, rdata, wdata, rd_word;
    logic [3:0] addr;
    logic wr, rd, lv;
    wdog_cfg_t wdog;       // Decoded watchdog setup
    mem_prot_t prot;       // Decoded memory options
    int err_count, checked;

    // Free-running 125 MHz clock
    initial begin
        mclk = 1'b0;
        forever #4 mclk = ~mclk;
    end

    config_word_decode i_dut (.i_mclk(mclk), .i_rst(rst),
        .i_cfg_reload(reload), .i_addr(addr), .i_wdata(wdata), .i_wr(wr),
        .i_rd(rd), .i_lv_prog_active(lv), .i_master_clear_pin_enable(mce),
        .i_wdog_software_enable(swen), .i_sleep(sleep),
        .i_ext_pm_wr(ext_wr), .i_ext_pm_rdata(ext_rd), .o_rdata(rdata),
        .o_wdog(wdog), .o_prot(prot), .o_ext_pm_wr_en(ext_wr_o),
        .o_ext_pm_rdata(ext_rd_o));

    cfg_programmer_model i_prog (.i_mclk(mclk), .i_rdata(rdata),
        .o_addr(addr), .o_wdata(wdata), .o_wr(wr), .o_rd(rd),
        .o_lv_prog_active(lv));

    // Single comparison point; four-state compare so X never matches
    task automatic check(input string what, input logic [16:0] seen,
                         input logic [16:0] exp);
        checked++;
        if (seen !== exp) begin
            err_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    task automatic rd_chk(input logic [3:0] a, input logic [13:0] exp);
        i_prog.get_word(a, rd_word);
        check("rdata", 17'(rd_word), 17'(exp));
    endtask : rd_chk

    // Stored words only reach the decode through a relatch
    task automatic relatch();
        @(posedge mclk);
        reload <= 1'b1;
        @(posedge mclk);
        reload <= 1'b0;
        @(posedge mclk);
        #1;
    endtask : relatch

    task automatic give_verdict();
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask : give_verdict

    // Blank device straight out of reset
    task automatic blank_case();
        // Blank clock field is 111, so the choice is left to software
        check("clk_src", 17'(wdog.clk_src), 17'(CLK_SOFTWARE));
        check("window", 17'(wdog.window), 17'h7);
        check("running", 17'(wdog.running), 17'h1);
        check("period", 17'(wdog.period), 17'h0b);
        check("per_lock", 17'(wdog.period_locked), 17'h0);
        check("mclr", 17'(prot.mclr_is_reset), 17'h1);
        check("boot_size", prot.boot_size, 17'h0);
        check("ee_prot", 17'(prot.eeprom_protected), 17'h0);
        check("ext_wr", 17'(ext_wr_o), 17'h1);
        check("ext_rd", 17'(ext_rd_o), 17'h2a5a);
        rd_chk(WDOG_WORD_ADDR, 14'h3fff);
        rd_chk(MEM_WORD_ADDR, 14'h3fff);
        rd_chk(CP_WORD_ADDR, 14'h3fff);
        rd_chk(4'h9, UNMAPPED_RDATA);
    endtask : blank_case

    // One watchdog word: read-back and decoded fields
    task automatic wd_case(input logic [2:0] cs, input logic [2:0] ws,
        input logic [4:0] ps, input wdog_clk_src_t ec, input logic [2:0] ew,
        input logic ewl, input logic [4:0] ep, input logic epl);
        i_prog.put_word(WDOG_WORD_ADDR, {cs, ws, 1'b0, 2'b11, ps});
        rd_chk(WDOG_WORD_ADDR, {cs, ws, 1'b1, 2'b11, ps});
        relatch();
        check("clk_src", 17'(wdog.clk_src), 17'(ec));
        check("window", 17'(wdog.window), 17'(ew));
        check("win_lock", 17'(wdog.window_locked), 17'(ewl));
        check("period", 17'(wdog.period), 17'(ep));
        check("per_lock", 17'(wdog.period_locked), 17'(epl));
    endtask : wd_case

    // Operating mode against sleep and the software enable
    task automatic md_case(input logic [1:0] md, input logic slp,
                           input logic sw, input logic exp);
        @(posedge mclk);
        sleep <= slp;
        swen <= sw;
        i_prog.put_word(WDOG_WORD_ADDR, {7'h7f, md, 5'h1f});
        relatch();
        check("running", 17'(wdog.running), 17'(exp));
    endtask : md_case

    // Low-voltage bit guarded during a session, then master clear
    task automatic lvp_case();
        i_prog.set_lv(1'b1);
        i_prog.put_word(MEM_WORD_ADDR, 14'h1fff);
        rd_chk(MEM_WORD_ADDR, 14'h3fff);
        i_prog.set_lv(1'b0);
        i_prog.put_word(MEM_WORD_ADDR, 14'h1fff);
        rd_chk(MEM_WORD_ADDR, 14'h1fff);
        relatch();
        check("hv_prog", 17'(prot.hv_prog_required), 17'h1);
        check("mclr", 17'(prot.mclr_is_reset), 17'h0);
        // With the low-voltage bit clear the supervisor enable decides
        @(posedge mclk);
        mce <= 1'b1;
        @(posedge mclk);
        #1;
        check("mclr_en", 17'(prot.mclr_is_reset), 17'h1);
        @(posedge mclk);
        mce <= 1'b0;
        i_prog.put_word(MEM_WORD_ADDR, 14'h3fff);
    endtask : lvp_case

    // Sticky protections, boot block sizing and bulk erase
    task automatic prot_case();
        i_prog.put_word(MEM_WORD_ADDR, 14'h397f);
        i_prog.put_word(MEM_WORD_ADDR, 14'h3fff);
        rd_chk(MEM_WORD_ADDR, 14'h397f);
        i_prog.put_word(MEM_WORD_ADDR, 14'h397e);
        i_prog.put_word(MEM_WORD_ADDR, 14'h3876);
        i_prog.put_word(MEM_WORD_ADDR, 14'h3877);
        rd_chk(MEM_WORD_ADDR, 14'h3876);
        relatch();
        check("ee_prot", 17'(prot.eeprom_protected), 17'h1);
        check("cfg_prot", 17'(prot.config_protected), 17'h1);
        check("app_prot", 17'(prot.app_protected), 17'h1);
        check("boot_en", 17'(prot.boot_enabled), 17'h1);
        check("boot_prot", 17'(prot.boot_protected), 17'h1);
        check("boot_size", prot.boot_size, 17'h00400);
        check("boot_last", 17'(prot.boot_last), 17'h003ff);
        check("saf_prot", 17'(prot.saf_protected), 17'h0);
        i_prog.put_word(ERASE_ADDR, 14'h0000);
        rd_chk(MEM_WORD_ADDR, 14'h3fff);
        // Unimplemented bits written low must still read high
        i_prog.put_word(MEM_WORD_ADDR, 14'h2780);
        rd_chk(MEM_WORD_ADDR, 14'h37e0);
        relatch();
        check("boot_size", prot.boot_size, 17'h04000);
        check("boot_last", 17'(prot.boot_last), 17'h03fff);
        check("saf_en", 17'(prot.saf_enabled), 17'h1);
        check("saf_prot", 17'(prot.saf_protected), 17'h1);
        check("ee_prot", 17'(prot.eeprom_protected), 17'h0);
        i_prog.put_word(ERASE_ADDR, 14'h0000);
    endtask : prot_case

    // Code protection gates external program memory access
    task automatic cp_case();
        i_prog.put_word(CP_WORD_ADDR, 14'h0000);
        i_prog.put_word(CP_WORD_ADDR, 14'h3fff);
        rd_chk(CP_WORD_ADDR, 14'h3ffe);
        relatch();
        check("ext_wr", 17'(ext_wr_o), 17'h0);
        check("ext_rd", 17'(ext_rd_o), 17'h0);
        i_prog.put_word(ERASE_ADDR, 14'h0000);
        relatch();
        check("ext_rd", 17'(ext_rd_o), 17'h2a5a);
    endtask : cp_case

    // Main sequence
    initial begin
        rst = 1'b1;
        reload = 1'b0;
        mce = 1'b0;
        swen = 1'b0;
        sleep = 1'b0;
        ext_wr = 1'b1;
        ext_rd = 14'h2a5a;
        err_count = 0;
        checked = 0;
        repeat (4) @(posedge mclk);
        rst <= 1'b0;
        @(posedge mclk);
        #1;
        blank_case();
        wd_case(3'h0, 3'h0, 5'h00, CLK_MED_FREQ_INTOSC, 3'h0, 1'b1, 5'h00,
                1'b1);
        wd_case(3'h1, 3'h5, 5'h12, CLK_LOW_FREQ_INTOSC, 3'h5, 1'b1, 5'h12,
                1'b1);
        wd_case(3'h2, 3'h6, 5'h13, CLK_RESERVED, 3'h7, 1'b0, 5'h00,
                1'b1);
        wd_case(3'h6, 3'h7, 5'h1e, CLK_RESERVED, 3'h7, 1'b0, 5'h00,
                1'b1);
        wd_case(3'h7, 3'h3, 5'h1f, CLK_SOFTWARE, 3'h3, 1'b1, 5'h0b,
                1'b0);
        md_case(2'b00, 1'b0, 1'b1, 1'b0);
        md_case(2'b01, 1'b0, 1'b1, 1'b1);
        md_case(2'b01, 1'b0, 1'b0, 1'b0);
        md_case(2'b11, 1'b1, 1'b0, 1'b1);
        md_case(2'b10, 1'b0, 1'b0, 1'b1);
        // Falling asleep suspends mode 10 one cycle later
        @(posedge mclk);
        sleep <= 1'b1;
        @(posedge mclk);
        #1;
        check("running", 17'(wdog.running), 17'h0);
        lvp_case();
        prot_case();
        cp_case();
        give_verdict();
    end

    // Cut a hang short
    initial begin
        #500000;
        err_count++;
        give_verdict();
    end
endmodule : config_word_decode_bench
`default_nettype wire
